// ===== design/tsr_pkg.sv
package tsr_pkg;
    localparam int NUM_STREAMS = 32;
    localparam int NUM_MEMS = 4;
    localparam int ADDR_W = 14;
    localparam int DATA_W = 16;

    // Register offsets
    localparam logic [13:0] BP_ADV_BASE = 14'h00a3;
    localparam logic [13:0] BP_ADV_LAST = 14'h00c2;
    localparam logic [13:0] MBIST_OFS = 14'h014d;
    localparam logic [13:0] RATE_OFS = 14'h1001;
    localparam logic [13:0] PART_ID_OFS = 14'h3fff;

    // Field positions
    localparam int BP_ADV_LSB = 0;
    localparam int TEST_EN_POS = 12;
    localparam int START_POS_TOP = 11;
    localparam int MEM_FIELD_STRIDE = 3;
    localparam int DONE_BELOW_START = 1;
    localparam int PASS_BELOW_START = 2;
    localparam int RATE_LSB = 1;
    localparam int REV_LSB = 4;
    localparam int DEV_LSB = 0;

    // Reset values
    localparam logic [1:0] BP_ADV_RST = 2'h0;
    localparam logic [1:0] RATE_RST = 2'h0;
    localparam logic [15:0] MBIST_RST = 16'h0000;

    // Timing counts in system clock cycles
    localparam int ADV_STEP_CYC = 2;
    localparam int FRAME_LEAD_CYC = 8;

    typedef enum logic [1:0] {
        TSR_RATE_2M = 2'b00,
        TSR_RATE_4M = 2'b01,
        TSR_RATE_8M = 2'b10,
        TSR_RATE_16M = 2'b11
    } tsr_rate_t;
endpackage

// ===== design/tsr_adv_delay.sv
`timescale 1ns/100ps
module tsr_adv_delay
    import tsr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic frame_early,
    input wire logic [1:0] adv_code,
    output logic stream_start
);
    localparam int SR_W = FRAME_LEAD_CYC - 1;
    logic [SR_W-1:0] sr;
    logic [2:0] tap;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sr <= '0;
        end else begin
            sr <= {sr[SR_W-2:0], frame_early};
        end
    end

    always_comb begin
        tap = 3'(SR_W - 1 - ADV_STEP_CYC * int'(adv_code));
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stream_start <= 1'b0;
        end else begin
            stream_start <= sr[tap];
        end
    end
endmodule

// ===== design/tsr_regs.sv
`timescale 1ns/100ps
// What this block does
// - Each backplane stream starts 0, 2, 4 or 6 clocks early per its code.
// - Code zero keeps the stream aligned with the generated frame pulse.
// - Self-test mode holds while enable bit 12 is high.
// - A test launches only on a start bit rising 0 to 1.
// - Read-only done flag rises when that memory test ends.
// - Read-only pass flag reports result, high meaning pass.
// - Two-bit rate selector sets one common stream rate, reset 2.048.
// - Identification register ignores host writes.
// - Identification reads revision at 7:4, part id at 2:0, rest zero.
module tsr_regs
    import tsr_pkg::*;
#(
    parameter logic [3:0] SILICON_REV = 4'h1, // Arbitrary value
    parameter logic [2:0] PART_ID = 3'h2 // Arbitrary value
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic up_cs_n,
    input wire logic up_rw,
    input wire logic [ADDR_W-1:0] up_addr,
    input wire logic [DATA_W-1:0] up_din,
    output logic [DATA_W-1:0] up_dout,
    output logic up_doe,
    output logic up_ack,
    input wire logic frame_early,
    output logic frame_pulse_out,
    output logic [NUM_STREAMS-1:0] bp_stream_start,
    output logic [1:0] stream_rate_sel,
    output logic self_test_enable,
    output logic [NUM_MEMS-1:0] mem_test_go,
    input wire logic [NUM_MEMS-1:0] mem_test_end,
    input wire logic [NUM_MEMS-1:0] mem_test_ok
);
    logic cs_n_s1, cs_n_s2, cs_n_d;
    logic rw_s1, rw_s2;
    logic [ADDR_W-1:0] addr_s1, addr_s2;
    logic [DATA_W-1:0] din_s1, din_s2;
    logic acc_start, wr_stb, rd_stb;
    logic [1:0] bp_adv [NUM_STREAMS];
    logic [NUM_MEMS-1:0] start_bits, done_flag, pass_flag, busy, launch;
    logic [13:0] adv_idx;
    logic [DATA_W-1:0] next_rdata;

    // Pins pass two flops before any use
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cs_n_s1 <= 1'b1;
            cs_n_s2 <= 1'b1;
            cs_n_d <= 1'b1;
            rw_s1 <= 1'b1;
            rw_s2 <= 1'b1;
            addr_s1 <= '0;
            addr_s2 <= '0;
            din_s1 <= '0;
            din_s2 <= '0;
        end else begin
            cs_n_s1 <= up_cs_n;
            cs_n_s2 <= cs_n_s1;
            cs_n_d <= cs_n_s2;
            rw_s1 <= up_rw;
            rw_s2 <= rw_s1;
            addr_s1 <= up_addr;
            addr_s2 <= addr_s1;
            din_s1 <= up_din;
            din_s2 <= din_s1;
        end
    end

    // One strobe per chip-select assertion; address and data ride the same sync delay
    assign acc_start = !cs_n_s2 && cs_n_d;
    assign wr_stb = acc_start && !rw_s2;
    assign rd_stb = acc_start && rw_s2;
    assign adv_idx = addr_s2 - BP_ADV_BASE;

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < NUM_STREAMS; i++) begin
                bp_adv[i] <= BP_ADV_RST;
            end
        end else if (wr_stb && addr_s2 >= BP_ADV_BASE && addr_s2 <= BP_ADV_LAST) begin
            bp_adv[adv_idx[4:0]] <= din_s2[BP_ADV_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            stream_rate_sel <= RATE_RST;
        end else if (wr_stb && addr_s2 == RATE_OFS) begin
            stream_rate_sel <= din_s2[RATE_LSB +: 2];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            self_test_enable <= MBIST_RST[TEST_EN_POS];
        end else if (wr_stb && addr_s2 == MBIST_OFS) begin
            self_test_enable <= din_s2[TEST_EN_POS];
        end
    end

    // launch on 0-to-1 of a start bit, only with enable already set
    always_comb begin
        for (int i = 0; i < NUM_MEMS; i++) begin
            launch[i] = wr_stb && addr_s2 == MBIST_OFS && self_test_enable && din_s2[TEST_EN_POS]
                && din_s2[START_POS_TOP - MEM_FIELD_STRIDE * i] && !start_bits[i];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            start_bits <= '0;
            mem_test_go <= '0;
        end else begin
            mem_test_go <= launch;
            if (wr_stb && addr_s2 == MBIST_OFS) begin
                for (int i = 0; i < NUM_MEMS; i++) begin
                    start_bits[i] <= din_s2[START_POS_TOP - MEM_FIELD_STRIDE * i];
                end
            end
        end
    end

    // done set wins over the launch clear; pass captured with it; launch clears
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            done_flag <= '0;
            pass_flag <= '0;
            busy <= '0;
        end else begin
            for (int i = 0; i < NUM_MEMS; i++) begin
                if (busy[i] && mem_test_end[i]) begin
                    done_flag[i] <= 1'b1;
                    pass_flag[i] <= mem_test_ok[i];
                    busy[i] <= 1'b0;
                end else if (launch[i]) begin
                    done_flag[i] <= 1'b0;
                    pass_flag[i] <= 1'b0;
                    busy[i] <= 1'b1;
                end
            end
        end
    end

    // read data mux for all registers incl. identification layout; no write path exists for identification
    always_comb begin
        next_rdata = '0;
        if (addr_s2 >= BP_ADV_BASE && addr_s2 <= BP_ADV_LAST) begin
            next_rdata[BP_ADV_LSB +: 2] = bp_adv[adv_idx[4:0]];
        end else if (addr_s2 == MBIST_OFS) begin
            next_rdata[TEST_EN_POS] = self_test_enable;
            for (int i = 0; i < NUM_MEMS; i++) begin
                next_rdata[START_POS_TOP - MEM_FIELD_STRIDE * i] = start_bits[i];
                next_rdata[START_POS_TOP - MEM_FIELD_STRIDE * i - DONE_BELOW_START] = done_flag[i];
                next_rdata[START_POS_TOP - MEM_FIELD_STRIDE * i - PASS_BELOW_START] = pass_flag[i];
            end
        end else if (addr_s2 == RATE_OFS) begin
            next_rdata[RATE_LSB +: 2] = stream_rate_sel;
        end else if (addr_s2 == PART_ID_OFS) begin
            next_rdata[REV_LSB +: 4] = SILICON_REV;
            next_rdata[DEV_LSB +: 3] = PART_ID;
        end
    end

    // Read data frozen at access start, held until the next read strobe; enable drops with chip select
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            up_dout <= '0;
            up_doe <= 1'b0;
            up_ack <= 1'b0;
        end else begin
            if (rd_stb) begin
                up_dout <= next_rdata;
            end
            up_doe <= !cs_n_s2 && rw_s2 && (up_doe || rd_stb);
            up_ack <= !cs_n_s2 && (up_ack || acc_start);
        end
    end

    tsr_adv_delay u_frame (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .frame_early(frame_early),
        .adv_code(2'h0),
        .stream_start(frame_pulse_out)
    );

    for (genvar g = 0; g < NUM_STREAMS; g++) begin : g_adv
        tsr_adv_delay u_adv (
            .clk_sys(clk_sys),
            .rstn(rstn),
            .frame_early(frame_early),
            .adv_code(bp_adv[g]),
            .stream_start(bp_stream_start[g])
        );
    end

    a_adv_zero_align: assert property (@(posedge clk_sys) disable iff (!rstn)
        bp_adv[0] == 2'h0 && $stable(bp_adv[0]) |-> bp_stream_start[0] == frame_pulse_out)
        else $error("stream 0 with zero advance not aligned to frame pulse");
    a_adv_six_early: assert property (@(posedge clk_sys) disable iff (!rstn)
        frame_early && bp_adv[3] == 2'h3 ##1 bp_adv[3] == 2'h3 |-> ##1 bp_stream_start[3] ##6 frame_pulse_out)
        else $error("advance of six cycles not met");
    a_go_needs_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
        |mem_test_go |-> self_test_enable)
        else $error("test launched outside self-test mode");
    a_go_rising_only: assert property (@(posedge clk_sys) disable iff (!rstn)
        mem_test_go[0] |-> !$past(start_bits[0], 2) && start_bits[0])
        else $error("test launched without start bit rising");
    a_done_from_end: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(done_flag[2]) |-> $past(mem_test_end[2]) && $past(busy[2]))
        else $error("done flag rose without test end");
    a_pass_result: assert property (@(posedge clk_sys) disable iff (!rstn)
        $rose(done_flag[1]) |-> pass_flag[1] == $past(mem_test_ok[1]))
        else $error("pass flag does not match result");
    a_launch_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
        launch[3] && !mem_test_end[3] |=> !done_flag[3] && !pass_flag[3])
        else $error("stale result survived launch");
    a_rate_write: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_stb && addr_s2 == RATE_OFS |=> stream_rate_sel == $past(din_s2[2:1]))
        else $error("rate selector not updated");
    a_id_readback: assert property (@(posedge clk_sys) disable iff (!rstn)
        rd_stb && addr_s2 == PART_ID_OFS |=> up_dout == {8'h00, SILICON_REV, 1'b0, PART_ID})
        else $error("identification read value wrong");
    a_id_readonly: assert property (@(posedge clk_sys) disable iff (!rstn)
        wr_stb && addr_s2 == PART_ID_OFS |=> $stable(stream_rate_sel) && $stable(self_test_enable))
        else $error("write to identification changed state");
    c_test_pass: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(done_flag[0]) && pass_flag[0]);
    c_test_fail: cover property (@(posedge clk_sys) disable iff (!rstn) $rose(done_flag[0]) && !pass_flag[0]);
    c_rate_16m: cover property (@(posedge clk_sys) disable iff (!rstn) stream_rate_sel == TSR_RATE_16M);
    c_adv_used: cover property (@(posedge clk_sys) disable iff (!rstn) bp_stream_start[1] && !frame_pulse_out);
endmodule

// ===== tb/tsr_mem_engine.sv
`timescale 1ns/100ps
module tsr_mem_engine #(
    parameter int LAT = 40
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [3:0] mem_test_go,
    input wire logic [3:0] pass_cfg,
    output logic [3:0] mem_test_end,
    output logic [3:0] mem_test_ok
);
    int cnt [4];
    // Result only valid with end; inverted otherwise so stale values never match
    assign mem_test_ok = (mem_test_end & pass_cfg) | (~mem_test_end & ~pass_cfg);
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            mem_test_end <= 4'h0;
            for (int i = 0; i < 4; i++) cnt[i] <= 0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                mem_test_end[i] <= (cnt[i] == 1);
                if (mem_test_go[i]) cnt[i] <= LAT;
                else if (cnt[i] != 0) cnt[i] <= cnt[i] - 1;
            end
        end
    end
endmodule

// ===== tb/tsr_regs_tb.sv
`timescale 1ns/100ps
module tsr_regs_tb;
    import tsr_pkg::*;
    // Arbitrary identification values
    localparam logic [3:0] REV = 4'h3;
    localparam logic [2:0] PID = 3'h5;
    logic clk_sys, rstn, up_cs_n, up_rw, up_doe, up_ack, frame_early, frame_pulse_out, self_test_enable;
    logic [13:0] up_addr;
    logic [15:0] up_din, up_dout, rd;
    logic [31:0] bp_stream_start;
    logic [1:0] stream_rate_sel;
    logic [3:0] mem_test_go, mem_test_end, mem_test_ok, pass_cfg;
    int err_count, samples_checked, go_cnt;
    tsr_regs #(.SILICON_REV(REV), .PART_ID(PID)) tsr_regs_i (.clk_sys(clk_sys), .rstn(rstn),
        .up_cs_n(up_cs_n), .up_rw(up_rw), .up_addr(up_addr), .up_din(up_din), .up_dout(up_dout),
        .up_doe(up_doe), .up_ack(up_ack), .frame_early(frame_early), .frame_pulse_out(frame_pulse_out),
        .bp_stream_start(bp_stream_start), .stream_rate_sel(stream_rate_sel),
        .self_test_enable(self_test_enable), .mem_test_go(mem_test_go), .mem_test_end(mem_test_end),
        .mem_test_ok(mem_test_ok));
    tsr_mem_engine tsr_mem_engine_i (.clk_sys(clk_sys), .rstn(rstn), .mem_test_go(mem_test_go),
        .pass_cfg(pass_cfg), .mem_test_end(mem_test_end), .mem_test_ok(mem_test_ok));
    initial begin
        clk_sys = 0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) go_cnt += $countones(mem_test_go);
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic fail_wait(string what);
        err_count++;
        $display("mismatch %s expected handshake seen none", what);
        test_done();
    endtask
    task automatic access(logic rw, logic [13:0] a, logic [15:0] d);
        int n;
        @(posedge clk_sys);
        up_cs_n <= 0; up_rw <= rw; up_addr <= a; up_din <= d;
        for (n = 0; n < 20 && up_ack !== 1'b1; n++) @(posedge clk_sys);
        if (n == 20) fail_wait("ack rise");
        rd = up_dout;
        if (rw) check("read data enable", {15'h0, up_doe}, 16'h1);
        up_cs_n <= 1;
        for (n = 0; n < 20 && up_ack !== 1'b0; n++) @(posedge clk_sys);
        if (n == 20) fail_wait("ack fall");
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic wait_cycles(int c);
        repeat (c) @(posedge clk_sys);
    endtask
    task automatic poll_done(logic [15:0] mask);
        int n;
        n = 0;
        do begin
            access(1, MBIST_OFS, 0);
            n++;
        end while (n < 10 && (rd & mask) !== mask);
        if ((rd & mask) !== mask) fail_wait("done flag poll");
    endtask
    task automatic t_reset_id();
        access(1, MBIST_OFS, 0); check("mbist reset", rd, 16'h0000);
        access(1, RATE_OFS, 0); check("rate reset", rd, 16'h0000);
        access(1, PART_ID_OFS, 0); check("part id", rd, {8'h00, REV, 1'b0, PID});
        access(0, PART_ID_OFS, 16'hffff);
        access(1, PART_ID_OFS, 0); check("part id after write", rd, {8'h00, REV, 1'b0, PID});
        access(1, 14'h0001, 0); check("unmapped read", rd, 16'h0000);
    endtask
    task automatic t_rate();
        for (int c = 3; c >= 0; c--) begin
            access(0, RATE_OFS, 16'(c << 1));
            access(1, RATE_OFS, 0); check("rate readback", rd, 16'(c << 1));
            check("rate out", {14'h0, stream_rate_sel}, 16'(c));
        end
    endtask
    task automatic t_bist();
        int g;
        pass_cfg <= 4'b0101;
        access(0, MBIST_OFS, 16'h1000);
        check("test mode on", {15'h0, self_test_enable}, 16'h1);
        g = go_cnt;
        access(0, MBIST_OFS, 16'h1924);
        check("launch count", 16'(go_cnt - g), 16'h4);
        poll_done(16'h0492);
        access(1, MBIST_OFS, 0); check("all done", rd & 16'hf6db, 16'h169a);
        g = go_cnt;
        access(0, MBIST_OFS, 16'h1924);
        check("no relaunch", 16'(go_cnt - g), 16'h0);
        access(0, MBIST_OFS, 16'h1000);
        pass_cfg <= 4'b1010;
        access(0, MBIST_OFS, 16'h1800);
        access(1, MBIST_OFS, 0); check("flags cleared", rd & 16'hf6db, 16'h109a);
        poll_done(16'h0400);
        access(1, MBIST_OFS, 0); check("fail result", rd & 16'hf6db, 16'h149a);
        access(0, MBIST_OFS, 16'h0000);
        check("test mode off", {15'h0, self_test_enable}, 16'h0);
        g = go_cnt;
        // start without prior enable write is refused
        access(0, MBIST_OFS, 16'h1800);
        check("launch without enable", 16'(go_cnt - g), 16'h0);
        access(0, MBIST_OFS, 16'h0000);
    endtask
    task automatic t_advance();
        int fp, st [4];
        for (int s = 0; s < 4; s++) access(0, BP_ADV_BASE + 14'(s), 16'(s));
        access(0, BP_ADV_LAST, 16'h0003);
        fp = -1;
        for (int s = 0; s < 4; s++) st[s] = -1;
        @(posedge clk_sys);
        frame_early <= 1;
        @(posedge clk_sys);
        frame_early <= 0;
        for (int c = 0; c < 16; c++) begin
            @(posedge clk_sys);
            if (frame_pulse_out === 1'b1) fp = c;
            for (int s = 0; s < 4; s++) if (bp_stream_start[s] === 1'b1) st[s] = c;
        end
        check("frame pulse seen", 16'(fp >= 0), 16'h1);
        check("stream zero aligned", 16'(st[0]), 16'(fp));
        for (int s = 1; s < 4; s++) check("stream lead", 16'(fp - st[s]), 16'(2 * s));
    endtask
    initial begin
        rstn = 0; up_cs_n = 1; up_rw = 1; up_addr = 0; up_din = 0; frame_early = 0;
        pass_cfg = 0; err_count = 0; samples_checked = 0; go_cnt = 0;
        wait_cycles(4);
        rstn <= 1;
        wait_cycles(2);
        t_reset_id();
        t_rate();
        t_bist();
        t_advance();
        test_done();
    end
endmodule
